// ---- include/cmp_shadow_pkg.sv ----
// constants for the compare shadow load control block
// assumes a 100 MHz peripheral clock and an APB register slave
package cmp_shadow_pkg;
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] COMPARE_VALUE_A_ADDR = 8'h04;
   localparam logic [7:0] COMPARE_VALUE_B_ADDR = 8'h08;
   localparam logic [7:0] CMPAW_ADDR = 8'h0C;
   localparam logic [7:0] PERIOD_ADDR = 8'h10;
   localparam logic [7:0] STATUS_ADDR = 8'h14;
   localparam logic [7:0] MASK_ADDR = 8'h18;
   localparam logic [7:0] EXT_ADDR = 8'h1C;
   localparam int A_SEL_LSB = 0;
   localparam int B_SEL_LSB = 2;
   localparam int A_DIRECT_BIT = 4;
   localparam int B_DIRECT_BIT = 6;
   localparam int A_FULL_BIT = 8;
   localparam int B_FULL_BIT = 9;
   localparam logic [15:0] CTRL_WMASK = 16'h005F;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] ZERO_COUNT = 16'h0000;
   localparam logic [1:0] LOAD_ZERO = 2'h0;
   localparam logic [1:0] LOAD_PERIOD = 2'h1;
   localparam logic [1:0] LOAD_EITHER = 2'h2;
   localparam logic [1:0] LOAD_FROZEN = 2'h3;
   localparam int NUM_EVENTS = 4;
endpackage : cmp_shadow_pkg

// ---- rtl/cmp_channel.sv ----
// one compare channel: shadow, active, pending flag, load strobe
// assumes strobes come from logic on the same clock
module cmp_channel
   import cmp_shadow_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_value,
   input wire logic set_flag,
   input wire logic [15:0] wdata,
   input wire logic direct,
   input wire logic [1:0] sel,
   input wire logic zero_evt,
   input wire logic period_evt,
   input wire logic [15:0] count,
   output logic [15:0] active,
   output logic [15:0] view,
   output logic pending,
   output logic loaded
);
   logic [15:0] shadow_q, shadow_d, active_q, active_d;
   logic pend_q, pend_d, strobe;
   always_comb begin
      unique case (sel)
         LOAD_ZERO: strobe = zero_evt;
         LOAD_PERIOD: strobe = period_evt;
         LOAD_EITHER: strobe = zero_evt | period_evt;
         LOAD_FROZEN: strobe = 1'b0;
      endcase
      strobe = strobe & ~direct;
      shadow_d = shadow_q;
      active_d = active_q;
      pend_d = pend_q;
      if (strobe) begin
         active_d = shadow_q;
         pend_d = 1'b0;
      end
      if (wr_value) begin
         if (direct) begin
            active_d = wdata;
         end else begin
            shadow_d = wdata;
            if (set_flag) begin
               pend_d = 1'b1;
            end
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shadow_q <= 16'h0000;
         active_q <= 16'h0000;
         pend_q <= 1'b0;
         loaded <= 1'b0;
      end else begin
         shadow_q <= shadow_d;
         active_q <= active_d;
         pend_q <= pend_d;
         loaded <= strobe;
      end
   end
   assign active = active_q;
   assign view = direct ? active_q : shadow_q;
   assign pending = pend_q;
   pend_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      strobe && !wr_value |=> !pend_q) else $error("pending flag not cleared by strobe");
   frozen_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      sel == LOAD_FROZEN && !(wr_value && direct) |=> $stable(active_q)) else $error("frozen active changed");
   direct_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_value && direct |=> active_q == $past(wdata)) else $error("direct write missed");
   overwrite_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_value && !direct |=> shadow_q == $past(wdata)) else $error("shadow not overwritten");
endmodule : cmp_channel

// ---- rtl/compare_shadow_load_control.sv ----
// top: APB registers, two compare channels, interrupts
// assumes count comes from the time-base on SYS_CLK; period is held in the PERIOD register
//
// Local design decisions: the APB register port and the register addresses.
module compare_shadow_load_control
   import cmp_shadow_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [15:0] TIMEBASE_COUNT,
   output logic MATCH_A,
   output logic MATCH_B,
   output logic CTR_ZERO,
   output logic CTR_PERIOD,
   output logic IRQ
);
   logic [15:0] ctrl_q, ctrl_d, period_q, period_d, ext_q, ext_d;
   logic [3:0] stat_q, stat_d, mask_q, mask_d;
   logic [31:0] rdata_d, rdata_q;
   logic ready_q, err_q, err_d, irq_d, irq_q;
   logic ma_q, mb_q, z_q, p_q;
   logic wr, rd, acc, lo16, zero_evt, period_evt;
   logic wr_a, set_a, wr_b;
   logic [15:0] act_a, act_b, view_a, view_b;
   logic pend_a, pend_b, load_a, load_b;
   logic [NUM_EVENTS-1:0] evt;
   assign acc = PSEL && PENABLE && !ready_q;
   // write commits at the edge where PREADY is sampled high
   assign wr = PSEL && PENABLE && PWRITE && ready_q;
   assign rd = acc && !PWRITE;
   assign lo16 = PSTRB[0] | PSTRB[1];
   assign zero_evt = TIMEBASE_COUNT == ZERO_COUNT;
   assign period_evt = TIMEBASE_COUNT == period_q;
   // 16-bit A write via low lanes, wide pair write via all lanes
   assign wr_a = wr && ((PADDR == COMPARE_VALUE_A_ADDR && lo16) || (PADDR == CMPAW_ADDR && PSTRB == 4'hF));
   assign set_a = wr_a;
   assign wr_b = wr && PADDR == COMPARE_VALUE_B_ADDR && lo16;
   cmp_channel u_a (
      .clk(SYS_CLK), .rst_n(RST_N), .wr_value(wr_a), .set_flag(set_a),
      .wdata(PADDR == CMPAW_ADDR ? PWDATA[31:16] : PWDATA[15:0]),
      .direct(ctrl_q[A_DIRECT_BIT]), .sel(ctrl_q[A_SEL_LSB+:2]),
      .zero_evt(zero_evt), .period_evt(period_evt), .count(TIMEBASE_COUNT),
      .active(act_a), .view(view_a), .pending(pend_a), .loaded(load_a)
   );
   cmp_channel u_b (
      .clk(SYS_CLK), .rst_n(RST_N), .wr_value(wr_b), .set_flag(wr_b),
      .wdata(PWDATA[15:0]),
      .direct(ctrl_q[B_DIRECT_BIT]), .sel(ctrl_q[B_SEL_LSB+:2]),
      .zero_evt(zero_evt), .period_evt(period_evt), .count(TIMEBASE_COUNT),
      .active(act_b), .view(view_b), .pending(pend_b), .loaded(load_b)
   );
   assign evt = {load_b, load_a, act_b == TIMEBASE_COUNT, act_a == TIMEBASE_COUNT};
   always_comb begin
      ctrl_d = ctrl_q;
      period_d = period_q;
      ext_d = ext_q;
      mask_d = mask_q;
      stat_d = stat_q;
      err_d = 1'b0;
      rdata_d = 32'h0000_0000;
      if (wr) begin
         unique case (PADDR)
            CTRL_ADDR: ctrl_d = PWDATA[15:0] & CTRL_WMASK;
            PERIOD_ADDR: period_d = PWDATA[15:0];
            MASK_ADDR: mask_d = PWDATA[3:0];
            EXT_ADDR: ext_d = PWDATA[15:0];
            CMPAW_ADDR: ext_d = (PSTRB == 4'hF) ? PWDATA[15:0] : ext_q;
            STATUS_ADDR: stat_d = stat_q & ~PWDATA[3:0];
            COMPARE_VALUE_A_ADDR, COMPARE_VALUE_B_ADDR: err_d = 1'b0;
            default: err_d = 1'b0;
         endcase
      end
      stat_d = stat_d | evt;
      // error decided in the first access cycle so it stands with PREADY
      if (acc && PWRITE && !(PADDR inside {CTRL_ADDR, COMPARE_VALUE_A_ADDR, COMPARE_VALUE_B_ADDR, CMPAW_ADDR, PERIOD_ADDR,
            STATUS_ADDR, MASK_ADDR, EXT_ADDR})) begin
         err_d = 1'b1;
      end
      if (rd) begin
         unique case (PADDR)
            CTRL_ADDR: begin
               rdata_d[15:0] = ctrl_q;
               rdata_d[A_FULL_BIT] = pend_a;
               rdata_d[B_FULL_BIT] = pend_b;
            end
            COMPARE_VALUE_A_ADDR: rdata_d[15:0] = view_a;
            COMPARE_VALUE_B_ADDR: rdata_d[15:0] = view_b;
            CMPAW_ADDR: rdata_d = {view_a, ext_q};
            PERIOD_ADDR: rdata_d[15:0] = period_q;
            STATUS_ADDR: rdata_d[3:0] = stat_q;
            MASK_ADDR: rdata_d[3:0] = mask_q;
            EXT_ADDR: rdata_d[15:0] = ext_q;
            default: err_d = 1'b1;
         endcase
      end
      irq_d = |(stat_q & mask_q);
   end
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         ctrl_q <= CTRL_RESET;
         period_q <= 16'h0000;
         ext_q <= 16'h0000;
         mask_q <= 4'h0;
         stat_q <= 4'h0;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         err_q <= 1'b0;
         irq_q <= 1'b0;
         ma_q <= 1'b0;
         mb_q <= 1'b0;
         z_q <= 1'b0;
         p_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         period_q <= period_d;
         ext_q <= ext_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         rdata_q <= rdata_d;
         ready_q <= acc;
         err_q <= err_d;
         irq_q <= irq_d;
         ma_q <= evt[0];
         mb_q <= evt[1];
         z_q <= zero_evt;
         p_q <= period_evt;
      end
   end
   assign PRDATA = rdata_q;
   assign PREADY = ready_q;
   assign PSLVERR = err_q;
   assign IRQ = irq_q;
   assign MATCH_A = ma_q;
   assign MATCH_B = mb_q;
   assign CTR_ZERO = z_q;
   assign CTR_PERIOD = p_q;
   match_a_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      act_a == TIMEBASE_COUNT |=> MATCH_A) else $error("match A missing");
   match_b_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      act_b != TIMEBASE_COUNT |=> !MATCH_B) else $error("spurious match B");
   zero_evt_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      TIMEBASE_COUNT == 16'h0000 |=> CTR_ZERO) else $error("zero event missing");
   ctrl_resv_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (ctrl_q & ~CTRL_WMASK) == 16'h0000) else $error("reserved control bits set");
   b_direct_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      wr_b && ctrl_q[B_DIRECT_BIT] && !pend_b |=> !pend_b) else $error("direct write set B flag");
   a_ext_only_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      wr && PADDR == EXT_ADDR && !pend_a && !load_a |=> !pend_a) else $error("extension write set A flag");
   apb_ready_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      PSEL && PENABLE && !PREADY |=> PREADY) else $error("apb answer late");
   irq_level_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      |(stat_q & mask_q) |=> IRQ) else $error("irq missing");
endmodule : compare_shadow_load_control

// ---- tb/tb_compare_shadow_load_control.sv ----
// bench for the compare shadow load control block
// assumes the time-base model and an APB master task
module tb_compare_shadow_load_control import cmp_shadow_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] P = 16'h0040;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, run = 0, e, pready, perr, ma, mb, cz, cp, irq;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, r, w;
   logic [3:0] pstrb = 4'h0;
   logic [15:0] hval = 16'h4000, cnt, v;
   logic [15:0] sh[2] = '{16'h0, 16'h0}, act[2] = '{16'h0, 16'h0};
   int pend[2], sel[2], dir[2], n_errors = 0, total_checks = 0, cyc = 0;
   always #5 clk = ~clk;
   timebase_model u_tb (.clk(clk), .rst_n(rst_n), .run(run), .hold_val(hval), .period(P), .count(cnt));
   compare_shadow_load_control u_dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(r), .PREADY(pready), .PSLVERR(perr),
      .TIMEBASE_COUNT(cnt), .MATCH_A(ma), .MATCH_B(mb), .CTR_ZERO(cz), .CTR_PERIOD(cp), .IRQ(irq));
   task wrap_up;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1; pen <= 0; pwr <= wr; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge clk);
      pen <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         $display("CHECK FAILED %0t apb no answer", $time);
      end
      w = r;
      e = perr;
      psel <= 0;
      pen <= 0;
   endtask : apb
   function automatic logic [31:0] ctl();
      return {22'h0, pend[1][0], pend[0][0], 1'b0, dir[1][0], 1'b0, dir[0][0], sel[1][1:0], sel[0][1:0]};
   endfunction : ctl
   task cchk;
      apb(0, CTRL_ADDR, 32'h0, 4'h0);
      chk(w, ctl());
   endtask : cchk
   task ev(input int z, input int p);
      for (int c = 0; c < 2; c++) begin
         if (!dir[c] && ((z && (sel[c] == 0 || sel[c] == 2)) || (p && (sel[c] == 1 || sel[c] == 2)))) begin
            act[c] = sh[c];
            pend[c] = 0;
         end
      end
   endtask : ev
   task park(input logic [15:0] pv);
      hval <= pv;
      repeat (3) @(posedge clk);
   endtask : park
   initial begin
      w = $urandom(41770);
      repeat (8) @(posedge clk);
      rst_n <= 1;
      apb(0, CTRL_ADDR, 32'h0, 4'h0); chk(w, {16'h0, CTRL_RESET});
      apb(1, CTRL_ADDR, 32'hFFFF, 4'hF); apb(0, CTRL_ADDR, 32'h0, 4'h0); chk(w, 32'h0000005F);
      apb(1, PERIOD_ADDR, {16'h0, P}, 4'hF);
      for (int ch = 0; ch < 2; ch++) begin
         for (int s = 0; s < 4; s++) begin
            sel[ch] = s; dir[0] = 0; dir[1] = 0;
            apb(1, CTRL_ADDR, ctl(), 4'hF);
            repeat (2) begin
               v = $urandom;
               apb(1, ch ? COMPARE_VALUE_B_ADDR : COMPARE_VALUE_A_ADDR, {16'h0, v}, 4'h3);
               sh[ch] = v; pend[ch] = 1;
            end
            apb(0, ch ? COMPARE_VALUE_B_ADDR : COMPARE_VALUE_A_ADDR, 32'h0, 4'h0); chk(w[15:0], sh[ch]);
            cchk();
            park(16'h0000); chk(cz, 1'b1); ev(1, 0); cchk();
            park(P); chk(cp, 1'b1); ev(0, 1); cchk();
            park(act[ch]); chk(ch ? mb : ma, 1'b1);
         end
      end
      dir[0] = 1; dir[1] = 1; sel[0] = 0; sel[1] = 0;
      apb(1, CTRL_ADDR, ctl(), 4'hF);
      for (int c = 0; c < 2; c++) begin
         v = $urandom; act[c] = v;
         apb(1, c ? COMPARE_VALUE_B_ADDR : COMPARE_VALUE_A_ADDR, {16'h0, v}, 4'h3);
      end
      cchk();
      park(16'h0000); park(act[1]); chk(mb, 1'b1);
      apb(0, COMPARE_VALUE_A_ADDR, 32'h0, 4'h0); chk(w[15:0], act[0]);
      dir[0] = 0; dir[1] = 0; sel[0] = 0; sel[1] = 0;
      apb(1, CTRL_ADDR, ctl(), 4'hF);
      park(16'h0000); ev(1, 0); cchk();
      sel[0] = 3; sel[1] = 3;
      apb(1, CTRL_ADDR, ctl(), 4'hF);
      apb(1, EXT_ADDR, $urandom, 4'hF); cchk();
      w = $urandom; sh[0] = w[31:16]; pend[0] = 1;
      apb(1, CMPAW_ADDR, w, 4'hF); cchk();
      apb(0, COMPARE_VALUE_A_ADDR, 32'h0, 4'h0); chk(w[15:0], sh[0]);
      apb(1, 8'h20, 32'h0, 4'hF); chk(e, 1'b1);
      dir[0] = 1; apb(1, CTRL_ADDR, ctl(), 4'hF);
      apb(1, COMPARE_VALUE_A_ADDR, 32'h3, 4'h3); apb(1, MASK_ADDR, 32'h1, 4'hF);
      run <= 1; repeat (2 * P) @(posedge clk);
      run <= 0; park(16'h4000); chk(irq, 1'b1);
      apb(1, STATUS_ADDR, 32'h1, 4'hF); repeat (3) @(posedge clk); chk(irq, 1'b0);
      wrap_up();
   end
endmodule : tb_compare_shadow_load_control

// ---- tb/timebase_model.sv ----
// time-base counter model feeding the compare block
// assumes the same clock and reset as the design
module timebase_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [15:0] hold_val,
   input wire logic [15:0] period,
   output logic [15:0] count
);
   timeunit 1ns;
   timeprecision 1ps;
   // parks on hold_val when stopped, else counts up and wraps at period
   always_ff @(posedge clk) begin
      if (!rst_n) count <= 16'h0000;
      else if (!run) count <= hold_val;
      else count <= (count >= period) ? 16'h0000 : count + 16'h0001;
   end
endmodule : timebase_model
